// File: rtl/clk_div_defines.vh
// Contract
// [RL1] Six selectable system clock sources
// [RL2] Instruction clock is oscillator over two
// [RL3] PLL out = in*M/(N1*N2)
// [RL4] VCO = in*M/N1
// [RL5] PLL modes use PLL output as oscillator; code ticks them every aclk cycle, as for fast RC, primary and low power
// [RL6] Interrupt clears enable when recover bit set
// [RL7] Reduction ratio 1..128, reset code 011
// [RL8] Enable off forces 1:1 ratio
// [RL9] Ratio writes ignored while enable set
// [RL10] Enable cannot set while ratio is 000
// [RL11] Fast RC postscale 1..256, reset 000
// [RL12] Output divider 2,4,reserved,8; reset 01
// [RL13] Bit 5 reads zero; bits 4-0 input divider
// [RL14] Ratio changes only at divided boundary; code applies a change to 1:1 at once
`ifndef CLK_DIV_DEFINES_VH
`define CLK_DIV_DEFINES_VH
`define ADDR_DIVISOR     4'h0
`define ADDR_SOURCE      4'h4
`define ADDR_FEEDBACK    4'h8
`define ADDR_STATUS      4'hC
`define RECOVER_BIT      15
`define DOZE_HI          14
`define DOZE_LO          12
`define REDUCE_EN_BIT    11
`define FAST_RC_HI       10
`define FAST_RC_LO       8
`define POST_HI          7
`define POST_LO          6
`define PRE_HI           4
`define PRE_LO           0
`define DIVISOR_RESET    16'h3040
`define DIVISOR_MASK     16'hFFDF
`define FEEDBACK_RESET   9'h030
`define SOURCE_RESET     3'h0
`define MULT_RESET       10'h032
`define IN_DIV_RESET     6'h02
`define OUT_DIV_RESET    4'h4
`define SRC_FAST_RC      3'h0
`define SRC_FAST_RC_PLL  3'h1
`define SRC_PRI          3'h2
`define SRC_PRI_PLL      3'h3
`define SRC_LOW_POWER    3'h5
`define SRC_FAST_RC_POST 3'h7
`endif

// File: rtl/pow2_divider.v
`timescale 1ns/10ps
module pow2_divider #(
   parameter CW = 8
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          tick_in,
   input  wire [CW-1:0] ratio_mask,
   output reg           tick_out
);
   reg [CW-1:0] count_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= {CW{1'b0}};
         tick_out  <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if ((count_reg & ratio_mask) == ratio_mask) begin
               count_reg <= {CW{1'b0}};
               tick_out  <= 1'b1;
            end else begin
               count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// File: rtl/clock_divisor_ctrl.v
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "clk_div_defines.vh"
module clock_divisor_ctrl (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        irq_event,
   output reg         instr_tick,
   output reg         periph_tick,
   output reg         cpu_tick,
   output reg  [2:0]  active_source,
   output reg         reserved_post
);
   reg [15:0] divisor_reg;
   reg [2:0]  source_reg;
   reg [8:0]  feedback_reg;
   reg [3:0]  aw_addr_reg;
   reg        aw_have_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg        w_have_reg;
   reg        osc_tick;
   reg        osc_phase_reg;
   reg [7:0]  doze_mask_reg;
   reg [7:0]  fast_rc_mask;
   reg [9:0]  mult_factor_reg;
   reg [5:0]  in_div_factor_reg;
   reg [3:0]  out_div_factor_reg;
   reg [7:0]  doze_mask_next;
   reg [15:0] divisor_next;
   reg [15:0] wr_val;
   reg [2:0]  doze_new;
   reg        aw_now;
   reg        w_now;
   reg        wr_go;
   reg [3:0]  wr_addr;
   reg [31:0] wr_data;
   reg [3:0]  wr_strb;
   wire       doze_tick;
   wire       fast_rc_tick;

   // Write channel capture, either order
   always @* begin
      aw_now  = s_axi_awvalid & s_axi_awready;
      w_now   = s_axi_wvalid & s_axi_wready;
      wr_go   = (aw_have_reg | aw_now) & (w_have_reg | w_now) &
                ~s_axi_bvalid;
      wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
      wr_data = w_have_reg ? w_data_reg : s_axi_wdata;
      wr_strb = w_have_reg ? w_strb_reg : s_axi_wstrb;
   end

   // Divisor register update
   always @* begin
      doze_new = 3'h0;
      wr_val = divisor_reg;
      if (wr_strb[0])
         wr_val[7:0] = wr_data[7:0];
      if (wr_strb[1])
         wr_val[15:8] = wr_data[15:8];
      wr_val = wr_val & `DIVISOR_MASK; // RL13
      divisor_next = divisor_reg;
      if (wr_go && wr_addr == `ADDR_DIVISOR) begin
         divisor_next = wr_val;
         if (divisor_reg[`REDUCE_EN_BIT])
            divisor_next[`DOZE_HI:`DOZE_LO] =
               divisor_reg[`DOZE_HI:`DOZE_LO]; // RL9
         doze_new = divisor_next[`DOZE_HI:`DOZE_LO];
         if (!divisor_reg[`REDUCE_EN_BIT] && doze_new == 3'h0)
            divisor_next[`REDUCE_EN_BIT] = 1'b0; // RL10
      end
      if (irq_event && divisor_reg[`RECOVER_BIT])
         divisor_next[`REDUCE_EN_BIT] = 1'b0; // RL6
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         aw_addr_reg   <= 4'h0;
         w_data_reg    <= 32'h0;
         w_strb_reg    <= 4'h0;
         divisor_reg   <= `DIVISOR_RESET; // RL7 RL11 RL12
         source_reg    <= `SOURCE_RESET;
         feedback_reg  <= `FEEDBACK_RESET;
      end else begin
         divisor_reg <= divisor_next;
         s_axi_awready <= ~aw_have_reg & ~aw_now & ~wr_go;
         s_axi_wready  <= ~w_have_reg & ~w_now & ~wr_go;
         if (wr_go) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= (wr_addr == `ADDR_STATUS ||
                              wr_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
            if (wr_addr == `ADDR_SOURCE && wr_strb[0])
               source_reg <= wr_data[2:0];
            if (wr_addr == `ADDR_FEEDBACK) begin
               if (wr_strb[0])
                  feedback_reg[7:0] <= wr_data[7:0];
               if (wr_strb[1])
                  feedback_reg[8] <= wr_data[8];
            end
         end else begin
            if (aw_now) begin
               aw_have_reg <= 1'b1;
               aw_addr_reg <= s_axi_awaddr;
            end
            if (w_now) begin
               w_have_reg <= 1'b1;
               w_data_reg <= s_axi_wdata;
               w_strb_reg <= s_axi_wstrb;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
               `ADDR_DIVISOR:  s_axi_rdata <= {16'h0, divisor_reg};
               `ADDR_SOURCE:   s_axi_rdata <= {29'h0, source_reg};
               `ADDR_FEEDBACK: s_axi_rdata <= {23'h0, feedback_reg};
               `ADDR_STATUS:   s_axi_rdata <= {3'h0, mult_factor_reg,
                                               out_div_factor_reg,
                                               in_div_factor_reg,
                                               reserved_post,
                                               active_source,
                                               doze_mask_reg[4:0]};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Fast RC postscaler mask
   always @* begin
      case (divisor_reg[`FAST_RC_HI:`FAST_RC_LO]) // RL11
         3'h0:    fast_rc_mask = 8'h00;
         3'h1:    fast_rc_mask = 8'h01;
         3'h2:    fast_rc_mask = 8'h03;
         3'h3:    fast_rc_mask = 8'h07;
         3'h4:    fast_rc_mask = 8'h0F;
         3'h5:    fast_rc_mask = 8'h1F;
         3'h6:    fast_rc_mask = 8'h3F;
         3'h7:    fast_rc_mask = 8'hFF;
         default: fast_rc_mask = 8'h00;
      endcase
   end

   pow2_divider #(.CW(8)) fast_rc_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick_in    (1'b1),
      .ratio_mask (fast_rc_mask),
      .tick_out   (fast_rc_tick)
   );

   // Source selection and oscillator rate
   always @* begin
      case (source_reg) // RL1 RL5
         `SRC_FAST_RC, `SRC_PRI, `SRC_LOW_POWER: osc_tick = 1'b1;
         `SRC_FAST_RC_PLL, `SRC_PRI_PLL:         osc_tick = 1'b1;
         `SRC_FAST_RC_POST:                      osc_tick = fast_rc_tick;
         default:                                osc_tick = 1'b1;
      endcase
   end

   // Loop factors: multiplier, input and output division
   always @(posedge aclk) begin
      if (!aresetn) begin
         mult_factor_reg    <= `MULT_RESET;
         in_div_factor_reg  <= `IN_DIV_RESET;
         out_div_factor_reg <= `OUT_DIV_RESET;
      end else begin
         mult_factor_reg    <= {1'b0, feedback_reg} + 10'h002; // RL3 RL4
         in_div_factor_reg  <= {1'b0, divisor_reg[`PRE_HI:`PRE_LO]} +
                               6'h02; // RL3 RL4
         out_div_factor_reg <= {1'b0, divisor_reg[`POST_HI:`POST_LO],
                                1'b0} + 4'h2; // RL3
      end
   end

   // Reduction ratio as mask, forced to 1:1 when disabled
   always @* begin
      doze_mask_next = 8'h00;
      if (divisor_reg[`REDUCE_EN_BIT]) // RL8
         doze_mask_next = ~(8'hFF << divisor_reg[`DOZE_HI:`DOZE_LO]);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_phase_reg <= 1'b0;
         instr_tick    <= 1'b0;
         periph_tick   <= 1'b0;
         cpu_tick      <= 1'b0;
         doze_mask_reg <= 8'h00;
         active_source <= `SOURCE_RESET;
         reserved_post <= 1'b0;
      end else begin
         instr_tick <= 1'b0;
         if (osc_tick) begin
            osc_phase_reg <= ~osc_phase_reg;
            instr_tick    <= osc_phase_reg; // RL2
         end
         periph_tick   <= instr_tick;
         cpu_tick      <= doze_tick;
         active_source <= source_reg;
         reserved_post <= divisor_reg[`POST_HI:`POST_LO] == 2'h2; // RL12
         if (doze_tick || doze_mask_reg == 8'h00 ||
             doze_mask_next == 8'h00)
            doze_mask_reg <= doze_mask_next; // RL14
      end
   end

   pow2_divider #(.CW(8)) doze_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick_in    (instr_tick),
      .ratio_mask (doze_mask_reg),
      .tick_out   (doze_tick)
   );
endmodule

// File: tb/clock_divisor_props.sv
`timescale 1ns/10ps
module clock_divisor_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instr_tick,
   input wire logic periph_tick,
   input wire logic cpu_tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_instr_half: assert property (instr_tick |=> !instr_tick)
      else $error("instruction tick twice in a row");
   a_periph_lag: assert property (periph_tick == $past(instr_tick))
      else $error("periph tick not one cycle after instruction tick");
   a_cpu_half: assert property (cpu_tick |=> !cpu_tick)
      else $error("cpu tick twice in a row");
   a_b_cause: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_wvalid && s_axi_wready || s_axi_awvalid && s_axi_awready))
      else $error("bvalid without a handshake");
   a_r_cause: assert property ($rose(s_axi_rvalid) |->
      $past(s_axi_arvalid && s_axi_arready))
      else $error("rvalid without a handshake");
   a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready while response pending");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stays after handshake");
   a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stays after handshake");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_cpu: cover property (cpu_tick);
endmodule
bind clock_divisor_ctrl clock_divisor_props props_u (.*);

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic aclk = '0, aresetn = '0, irq_event = '0, s_axi_bready = '0;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '1;
   logic [31:0] s_axi_wdata = '0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, instr_tick, periph_tick, cpu_tick, reserved_post;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0] active_source;
   integer bad_count = 0, num_checks = 0, cyc = 0, f, p, i;
   logic [2:0] srcs [0:5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
   clock_divisor_ctrl dut_u (.*);
   initial forever #4 aclk = ~aclk;
   task end_of_test;
      if (bad_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 100000) begin
         bad_count++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] g, e, input integer t);
      num_checks++;
      if (g !== e && (t == 0 || (g > e ? g - e : e - g) > t)) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r, 0);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, e, 0);
      chk(s_axi_rresp, r, 0);
   endtask
   task cnt(input integer c);
      f = 0;
      p = 0;
      repeat (c) begin
         @(posedge aclk);
         f += instr_tick;
         p += cpu_tick;
      end
   endtask
   task irq;
      @(posedge aclk) irq_event <= 1'h1;
      @(posedge aclk) irq_event <= 1'h0;
   endtask
   task t_regs;
      rd(4'h0, 32'h3040, 2'h0);
      wr(4'h0, 32'h27, 2'h0);
      rd(4'h0, 32'h7, 2'h0);
      wr(4'h0, 32'h800, 2'h0);
      rd(4'h0, 32'h0, 2'h0);
      wr(4'hC, 32'h0, 2'h2);
      wr(4'h0, 32'h80, 2'h0);
      cnt(4);
      chk(reserved_post, 1'h1, 0);
      wr(4'h0, 32'hC0, 2'h0);
      cnt(4);
      chk(reserved_post, 1'h0, 0);
      wr(4'h0, 32'hC5, 2'h0);
      wr(4'h8, 32'h1FF, 2'h0);
      rd(4'hC, 32'h100C0E00, 2'h0);
   endtask
   task t_doze;
      for (i = 1; i < 8; i++) begin
         wr(4'h0, i << 12, 2'h0);
         wr(4'h0, (i << 12) | 32'h800, 2'h0);
         cnt(1024);
         chk(p, 512 >> i, 1);
      end
      wr(4'h0, 32'h5800, 2'h0);
      rd(4'h0, 32'h7800, 2'h0);
      wr(4'h0, 32'h0, 2'h0);
      cnt(256);
      chk(p, f, 1);
      chk(f, 128, 1);
   endtask
   task t_roi;
      wr(4'h0, 32'hB800, 2'h0);
      irq;
      rd(4'h0, 32'hB000, 2'h0);
      wr(4'h0, 32'h3800, 2'h0);
      irq;
      rd(4'h0, 32'h3800, 2'h0);
   endtask
   task t_src;
      wr(4'h0, 32'h0, 2'h0);
      for (i = 0; i < 6; i++) begin
         wr(4'h4, srcs[i], 2'h0);
         cnt(1024);
         chk(active_source, srcs[i], 0);
         chk(f, 512, 1);
      end
      for (i = 0; i < 8; i++) begin
         wr(4'h0, i << 8, 2'h0);
         cnt(4096);
         chk(f, i == 7 ? 8 : 2048 >> i, 1);
      end
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      t_regs;
      t_doze;
      t_roi;
      t_src;
      end_of_test;
   end
endmodule
